// >>> core/hmw_defines.svh
`ifndef HMW_DEFINES_SVH
`define HMW_DEFINES_SVH
// Host register offsets (byte addresses on the 8-bit host port).
`define HMW_OFF_DATA_B0 4'h4
`define HMW_OFF_DATA_B1 4'h5
`define HMW_OFF_DATA_B2 4'h6
`define HMW_OFF_DATA_B3 4'h7
`define HMW_OFF_FLAGS_LO 4'h8
`define HMW_OFF_FLAGS_HI 4'h9
`define HMW_OFF_MASK_LO 4'ha
`define HMW_OFF_MASK_HI 4'hb
`define HMW_OFF_ACCESS 4'h2
// Field positions and reset values.
`define HMW_OUTBOX_BIT 0
`define HMW_RESET_BYTE 8'h00
`define HMW_RESET_ACCESS 2'h0
`endif

// >>> core/hmw_pkg.sv
package hmw_pkg;
	// Kind of data window access selected by the host.
	typedef enum logic [1:0] {
		HMW_ACC_8 = 2'b00,
		HMW_ACC_16 = 2'b01,
		HMW_ACC_32 = 2'b10,
		HMW_ACC_32_AUTO = 2'b11
	} hmw_access_t;
endpackage : hmw_pkg

// >>> core/hmw_flag_bit.sv
`include "hmw_defines.svh"
// One software event flag: firmware sets it, host clears it by writing one when permitted.
module hmw_flag_bit (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic fw_set,
	input wire logic host_clr,
	input wire logic clr_allow,
	output logic flag
);
	// A set in the same cycle as a clear wins, so no event is lost.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag <= 1'b0;
		end else if (fw_set) begin
			flag <= 1'b1;
		end else if (host_clr && clr_allow) begin
			flag <= 1'b0;
		end
	end
endmodule : hmw_flag_bit

// >>> core/hmw_host_window.sv
// Operation
// - Offset 04h holds window data byte zero.
// - Offsets 05h, 06h hold data bytes one, two.
// - Offset 07h holds byte three; all reset zero.
// - Low flag bits 7:1 are firmware event flags.
// - High flag register bits are firmware event flags.
// - Host write of one clears a flag.
// - Without clear permission, host clear is ignored.
// - Outbox flag is read-only, set on outbox write.
// - Events raise interrupt only when enabled in mask.
// - Access type selects 8, 16, 32, auto-32.
//
// Strobed register access was chosen for this implementation.
`include "hmw_defines.svh"
module hmw_host_window
	import hmw_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic [14:0] FW_SET,
	input wire logic [14:0] FW_CLR_ALLOW,
	input wire logic FW_OUTBOX_WR,
	input wire logic HOST_OUTBOX_CLR,
	input wire logic [31:0] FW_DATA,
	input wire logic FW_DATA_LOAD,
	output logic [31:0] WINDOW_DATA,
	output logic [1:0] ACCESS_TYPE,
	output logic WINDOW_RD_STROBE,
	output logic WINDOW_WR_STROBE,
	output logic IRQ
);
	// Window data bytes, one per byte lane.
	logic [7:0] window_data_reg [4];
	// Access type chosen by the host.
	hmw_access_t access_reg;
	// Outbox-written flag and the fifteen software flags.
	logic outbox_written_flag;
	logic [14:0] soft_flags;
	// Interrupt enables: bit 0 outbox, bits 15:1 software flags.
	logic [15:0] enable_reg;
	// Full sixteen-bit source view as the host sees it.
	logic [15:0] source_view;

	// Decode for one host register offset.
	// Register writes and the strobes compare the offset through this helper; the read mux and the checks compare ADDR directly.
	// A change of address width then touches the helper, the read mux and the checks.
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction : hit

	// Data window bytes; host writes per byte, firmware may load a whole word.
	// A host byte write wins over a firmware load in the same cycle.
	// The firmware then sees its load lost only in that byte lane.
	// The host never sees a half-updated byte as a result.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_byte
			always_ff @(posedge CLK_SYS or negedge RST_B) begin
				if (!RST_B) begin
					window_data_reg[gi] <= `HMW_RESET_BYTE;
				end else if (WR && hit(ADDR, `HMW_OFF_DATA_B0 + 4'(gi))) begin
					window_data_reg[gi] <= WDATA;
				end else if (FW_DATA_LOAD) begin
					window_data_reg[gi] <= FW_DATA[gi*8 +: 8];
				end
			end
		end
	endgenerate

	// The word handed to the memory side is built straight from the byte flip-flops.
	// Byte zero is the least significant lane.
	assign WINDOW_DATA = {window_data_reg[3], window_data_reg[2], window_data_reg[1], window_data_reg[0]};

	// Access type register.
	// It sits in the two low bits of the address register offset.
	// Every code is legal, so no value needs to be refused.
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			access_reg <= HMW_ACC_8;
		end else if (WR && hit(ADDR, `HMW_OFF_ACCESS)) begin
			access_reg <= hmw_access_t'(WDATA[1:0]);
		end
	end
	// The memory side reads the chosen access kind from here.
	assign ACCESS_TYPE = access_reg;

	// Window strobes: the last byte of the selected width triggers the memory access.
	// Software writes the lower bytes first and the strobe byte last.
	// Writing bytes out of that order starts the access with stale lower bytes.
	// A read is started by reading byte zero, whatever the width.
	logic [3:0] last_off;
	always_comb begin
		case (access_reg)
			HMW_ACC_8: last_off = `HMW_OFF_DATA_B0;
			HMW_ACC_16: last_off = `HMW_OFF_DATA_B1;
			HMW_ACC_32: last_off = `HMW_OFF_DATA_B3;
			HMW_ACC_32_AUTO: last_off = `HMW_OFF_DATA_B3;
			default: last_off = `HMW_OFF_DATA_B0;
		endcase
	end
	assign WINDOW_WR_STROBE = WR && hit(ADDR, last_off);
	assign WINDOW_RD_STROBE = RD && hit(ADDR, `HMW_OFF_DATA_B0);

	// Outbox flag: set by firmware outbox write, cleared only by outbox clear; set wins.
	// Letting the set win keeps a new message from being lost.
	// That could happen when the host clears the old one in the same cycle.
	// Host writes to the flag register never reach this bit.
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			outbox_written_flag <= 1'b0;
		end else if (FW_OUTBOX_WR) begin
			outbox_written_flag <= 1'b1;
		end else if (HOST_OUTBOX_CLR) begin
			outbox_written_flag <= 1'b0;
		end
	end

	// Host write-one-to-clear strobes for software flags; bit 0 of low register dropped.
	// Bit i of this vector clears soft flag i.
	// Flags 0 to 6 sit in low register bits 7:1.
	// Flags 7 to 14 sit in the high register.
	logic [14:0] host_clr;
	assign host_clr = {({8{WR && hit(ADDR, `HMW_OFF_FLAGS_HI)}} & WDATA),
		({7{WR && hit(ADDR, `HMW_OFF_FLAGS_LO)}} & WDATA[7:1])};

	// Software flags, one cell each.
	// Firmware withholds clear permission while the cause of an event lasts.
	// Each cell lets a firmware set win over a host clear in the same cycle.
	// The permission input is a level and is sampled on every edge.
	generate
		for (gi = 0; gi < 15; gi++) begin : g_flag
			hmw_flag_bit u_flag (
				.clk(CLK_SYS),
				.rst_b(RST_B),
				.fw_set(FW_SET[gi]),
				.host_clr(host_clr[gi]),
				.clr_allow(FW_CLR_ALLOW[gi]),
				.flag(soft_flags[gi])
			);
		end
	endgenerate

	// The host view puts the outbox flag at bit 0 and the soft flags above it.
	// The enable register uses the same layout, so one AND gives the interrupt.
	assign source_view = {soft_flags, outbox_written_flag};

	// Interrupt enable registers.
	// Low byte at its offset, high byte at the next one.
	// Both clear on reset, so no interrupt can leave the block before software enables it.
	// Each byte is written on its own; the other keeps its value.
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			enable_reg <= 16'h0000;
		end else begin
			if (WR && hit(ADDR, `HMW_OFF_MASK_LO)) begin
				enable_reg[7:0] <= WDATA;
			end
			if (WR && hit(ADDR, `HMW_OFF_MASK_HI)) begin
				enable_reg[15:8] <= WDATA;
			end
		end
	end

	// Level interrupt while any enabled flag is set.
	// It drops as soon as the last enabled flag is cleared or masked.
	// No edge is stored, so a masked flag that is later enabled still interrupts.
	assign IRQ = |(source_view & enable_reg);

	// Read data, valid in the cycle after the read strobe.
	// Outside that cycle the port returns zero.
	// Stale data then cannot be mistaken for a new answer.
	// Unmapped offsets also read as zero.
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			case (ADDR)
				`HMW_OFF_ACCESS: RDATA <= {6'h00, access_reg};
				`HMW_OFF_DATA_B0: RDATA <= window_data_reg[0];
				`HMW_OFF_DATA_B1: RDATA <= window_data_reg[1];
				`HMW_OFF_DATA_B2: RDATA <= window_data_reg[2];
				`HMW_OFF_DATA_B3: RDATA <= window_data_reg[3];
				`HMW_OFF_FLAGS_LO: RDATA <= source_view[7:0];
				`HMW_OFF_FLAGS_HI: RDATA <= source_view[15:8];
				`HMW_OFF_MASK_LO: RDATA <= enable_reg[7:0];
				`HMW_OFF_MASK_HI: RDATA <= enable_reg[15:8];
				default: RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	// Checks on the host-visible behaviour.
	// Each property names its own clock and reset so that it reads on its own.
	// Firmware inputs are free here, so antecedents exclude same-cycle sets.
	// A permitted host clear of high flag bit 0 takes effect.
	chk_clear_works: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(WR && ADDR == `HMW_OFF_FLAGS_HI && WDATA[0] && FW_CLR_ALLOW[7] && !FW_SET[7]) |=> !soft_flags[7])
		else $error("Permitted clear failed");

	// A flag without clear permission stays set.
	chk_clear_blocked: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(soft_flags[0] && !FW_CLR_ALLOW[0]) |=> soft_flags[0])
		else $error("Blocked clear took effect");

	// A firmware set of the top flag is never lost.
	chk_set_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		FW_SET[14] |=> soft_flags[14])
		else $error("Set lost");

	// A firmware outbox write sets the outbox flag.
	chk_outbox_set: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		FW_OUTBOX_WR |=> outbox_written_flag)
		else $error("Outbox flag not set");

	// The outbox flag holds until the outbox is cleared.
	chk_outbox_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(outbox_written_flag && !HOST_OUTBOX_CLR) |=> outbox_written_flag)
		else $error("Outbox flag dropped");

	// Clearing the outbox clears its flag.
	chk_outbox_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(HOST_OUTBOX_CLR && !FW_OUTBOX_WR) |=> !outbox_written_flag)
		else $error("Outbox flag not cleared");

	// With every enable off the interrupt stays low.
	chk_irq_mask: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(enable_reg == 16'h0000) |-> !IRQ)
		else $error("Masked interrupt raised");

	// A host write lands in byte two.
	chk_byte_write: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(WR && ADDR == `HMW_OFF_DATA_B2) |=> (WINDOW_DATA[23:16] == $past(WDATA)))
		else $error("Byte two not written");

	// A read of byte zero returns the stored byte.
	chk_read_back: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(RD && ADDR == `HMW_OFF_DATA_B0) |=> (RDATA == $past(window_data_reg[0])))
		else $error("Byte zero read wrong");

	// A write to the address register stores the access kind.
	chk_access_sel: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(WR && ADDR == `HMW_OFF_ACCESS) |=> (ACCESS_TYPE == $past(WDATA[1:0])))
		else $error("Access type not stored");

	// A permitted host clear of low flag bit 1 takes effect.
	chk_low_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(WR && ADDR == `HMW_OFF_FLAGS_LO && WDATA[1] && FW_CLR_ALLOW[0] && !FW_SET[0]) |=> !soft_flags[0])
		else $error("Permitted low clear failed");

	// The top flag without permission stays set.
	chk_high_blocked: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(soft_flags[14] && !FW_CLR_ALLOW[14]) |=> soft_flags[14])
		else $error("Blocked high clear took effect");

	// A firmware set of the lowest soft flag is never lost.
	chk_set_low: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		FW_SET[0] |=> soft_flags[0])
		else $error("Low set lost");

	// Writing zeros leaves the soft flags alone.
	chk_zero_write: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(WR && ADDR == `HMW_OFF_FLAGS_LO && WDATA == 8'h00 && FW_SET == 15'h0000) |=> (soft_flags == $past(soft_flags)))
		else $error("Zero write changed a flag");

	// Host writes to the low flag register never touch the outbox flag.
	chk_outbox_ro: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(WR && ADDR == `HMW_OFF_FLAGS_LO && !FW_OUTBOX_WR && !HOST_OUTBOX_CLR) |=> (outbox_written_flag == $past(outbox_written_flag)))
		else $error("Host write changed the outbox flag");

	// An enabled high flag raises the interrupt.
	chk_irq_level: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(soft_flags[8] && enable_reg[9]) |-> IRQ)
		else $error("Enabled flag gave no interrupt");

	// With no flag set the interrupt stays low.
	chk_irq_off: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(source_view == 16'h0000) |-> !IRQ)
		else $error("Interrupt without a flag");

	// A host write lands in byte zero.
	chk_byte_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(WR && ADDR == `HMW_OFF_DATA_B0) |=> (WINDOW_DATA[7:0] == $past(WDATA)))
		else $error("Byte zero not written");

	// A host write lands in byte one.
	chk_byte_one: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(WR && ADDR == `HMW_OFF_DATA_B1) |=> (WINDOW_DATA[15:8] == $past(WDATA)))
		else $error("Byte one not written");

	// A host write lands in byte three.
	chk_byte_three: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(WR && ADDR == `HMW_OFF_DATA_B3) |=> (WINDOW_DATA[31:24] == $past(WDATA)))
		else $error("Byte three not written");

	// A read of the high flag register returns the upper soft flags.
	chk_flags_read: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(RD && ADDR == `HMW_OFF_FLAGS_HI) |=> (RDATA == $past(soft_flags[14:7])))
		else $error("High flags read wrong");

	// Read data stands only in the cycle after a read.
	chk_rdata_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!RD |=> (RDATA == 8'h00))
		else $error("Read data outside its cycle");

	// In byte mode a write of byte zero starts the access.
	chk_strobe_byte: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(WR && ADDR == `HMW_OFF_DATA_B0 && access_reg == HMW_ACC_8) |-> WINDOW_WR_STROBE)
		else $error("Byte access not started");

	// In half-word mode a write of byte one starts the access.
	chk_strobe_half: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(WR && ADDR == `HMW_OFF_DATA_B1 && access_reg == HMW_ACC_16) |-> WINDOW_WR_STROBE)
		else $error("Half-word access not started");

	// In both word modes a write of byte three starts the access.
	chk_strobe_word: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(WR && ADDR == `HMW_OFF_DATA_B3 && access_reg[1]) |-> WINDOW_WR_STROBE)
		else $error("Word access not started");

	// The write strobe never comes without a host write.
	chk_strobe_only: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		WINDOW_WR_STROBE |-> WR)
		else $error("Write strobe without a write");

	// The read strobe comes only with a read of byte zero.
	chk_rd_strobe: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		WINDOW_RD_STROBE |-> (RD && ADDR == `HMW_OFF_DATA_B0))
		else $error("Read strobe at the wrong offset");

	// The interrupt rises.
	cov_irq: cover property (@(posedge CLK_SYS) disable iff (!RST_B) $rose(IRQ));
	// A firmware set meets a host clear.
	cov_race: cover property (@(posedge CLK_SYS) disable iff (!RST_B) FW_SET[0] && host_clr[0]);
	// An auto-increment word access starts.
	cov_auto: cover property (@(posedge CLK_SYS) disable iff (!RST_B) WINDOW_WR_STROBE && access_reg == HMW_ACC_32_AUTO);
	// A host clear is refused for want of permission.
	cov_refused: cover property (@(posedge CLK_SYS) disable iff (!RST_B) host_clr[0] && !FW_CLR_ALLOW[0] && soft_flags[0]);
	// The outbox flag is cleared by the host.
	cov_outbox_clr: cover property (@(posedge CLK_SYS) disable iff (!RST_B) HOST_OUTBOX_CLR && outbox_written_flag);
endmodule : hmw_host_window

// >>> test/hmw_fw_model.sv
// Firmware side of the window block: raises events and grants host-clear permission.
module hmw_fw_model (
	input wire logic clk,
	output logic [14:0] fw_set,
	output logic [14:0] clr_allow,
	output logic outbox_wr
);
	timeunit 1ns;
	timeprecision 1ns;
	// Firmware starts quiet and withholds every clear permission.
	initial begin
		fw_set = '0;
		clr_allow = '0;
		outbox_wr = 1'b0;
	end
	// Raises the chosen soft flags and the outbox event for one cycle.
	task automatic raise(input logic [14:0] m, input logic ob);
		@(posedge clk);
		fw_set <= m;
		outbox_wr <= ob;
		@(posedge clk);
		fw_set <= '0;
		outbox_wr <= 1'b0;
	endtask : raise
	// Grants host-clear permission only for events whose cause has ended.
	task automatic permit(input logic [14:0] m);
		@(posedge clk);
		clr_allow <= m;
	endtask : permit
endmodule : hmw_fw_model

// >>> test/testbench.sv
// Host-side bench for the window data bytes and event flags.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_SYS = 1'b0;
	logic RST_B = 1'b0;
	logic [3:0] ADDR = '0;
	logic [7:0] WDATA = '0;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic HOST_OUTBOX_CLR = 1'b0;
	logic [31:0] FW_DATA = '0;
	logic FW_DATA_LOAD = 1'b0;
	logic [7:0] RDATA;
	logic [14:0] FW_SET, FW_CLR_ALLOW;
	logic FW_OUTBOX_WR, IRQ, WINDOW_RD_STROBE, WINDOW_WR_STROBE;
	logic [31:0] WINDOW_DATA;
	logic [1:0] ACCESS_TYPE;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	// Counts of window strobes seen at clock edges, and a snapshot for deltas.
	int n_wr_strobe = 0;
	int n_rd_strobe = 0;
	int snap = 0;
	// The 50 MHz system clock.
	always #10 CLK_SYS = ~CLK_SYS;
	hmw_host_window i_dut (.CLK_SYS, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA, .FW_SET, .FW_CLR_ALLOW,
		.FW_OUTBOX_WR, .HOST_OUTBOX_CLR, .FW_DATA, .FW_DATA_LOAD, .WINDOW_DATA, .ACCESS_TYPE,
		.WINDOW_RD_STROBE, .WINDOW_WR_STROBE, .IRQ);
	hmw_fw_model i_fw (.clk(CLK_SYS), .fw_set(FW_SET), .clr_allow(FW_CLR_ALLOW), .outbox_wr(FW_OUTBOX_WR));
	// Compares a value seen at the ports with the expected one.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One-cycle host write; the strobe drops at the edge that takes it.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLK_SYS);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
	endtask : wr
	// One-cycle host read; the data stand only in the following cycle.
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
		@(posedge CLK_SYS);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK_SYS);
		RD <= 1'b0;
		#1 chk(what, {24'h0, e}, {24'h0, RDATA});
	endtask : rd
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out
	// Cuts a hang short well beyond the hundred or so cycles the tests need.
	always @(posedge CLK_SYS) begin
		cycles++;
		if (WINDOW_WR_STROBE === 1'b1) begin
			n_wr_strobe++;
		end
		if (WINDOW_RD_STROBE === 1'b1) begin
			n_rd_strobe++;
		end
		if (cycles == 2000) begin
			miscompares++;
			close_out();
		end
	end
	// Main sequence of tests.
	initial begin
		repeat (4) @(posedge CLK_SYS);
		RST_B <= 1'b1;
		for (int a = 4; a < 12; a++) rd(a[3:0], 8'h00, "reset value");
		$display("Test reset values ended.");
		for (int a = 4; a < 8; a++) wr(a[3:0], 8'h11 * a[7:0]);
		for (int a = 4; a < 8; a++) rd(a[3:0], 8'h11 * a[7:0], "data byte");
		chk("window word", 32'h77665544, WINDOW_DATA);
		rd(4'hf, 8'h00, "unmapped read");
		@(posedge CLK_SYS);
		FW_DATA <= 32'hcafe0123;
		FW_DATA_LOAD <= 1'b1;
		@(posedge CLK_SYS);
		FW_DATA_LOAD <= 1'b0;
		rd(4'h7, 8'hca, "loaded byte");
		$display("Test window bytes ended.");
		i_fw.raise(15'h7fff, 1'b1);
		rd(4'h8, 8'hff, "flags low");
		rd(4'h9, 8'hff, "flags high");
		chk("irq masked", 32'h0, {31'h0, IRQ});
		wr(4'h8, 8'h00);
		rd(4'h8, 8'hff, "zero write");
		wr(4'h8, 8'hff);
		rd(4'h8, 8'hff, "clear refused");
		i_fw.permit(15'h00ff);
		wr(4'h8, 8'hff);
		rd(4'h8, 8'h01, "clear low");
		wr(4'h9, 8'hff);
		rd(4'h9, 8'hfe, "clear high");
		$display("Test event flags ended.");
		wr(4'ha, 8'h01);
		#1 chk("irq outbox", 32'h1, {31'h0, IRQ});
		wr(4'ha, 8'h00);
		wr(4'hb, 8'h01);
		#1 chk("irq cleared", 32'h0, {31'h0, IRQ});
		wr(4'hb, 8'h02);
		#1 chk("irq high", 32'h1, {31'h0, IRQ});
		@(posedge CLK_SYS);
		HOST_OUTBOX_CLR <= 1'b1;
		@(posedge CLK_SYS);
		HOST_OUTBOX_CLR <= 1'b0;
		rd(4'h8, 8'h00, "outbox cleared");
		for (int t = 0; t < 4; t++) begin
			wr(4'h2, t[7:0]);
			#1 chk("access type", t, {30'h0, ACCESS_TYPE});
		end
		$display("Test interrupts and access ended.");
		snap = n_wr_strobe;
		wr(4'h4, 8'h12);
		wr(4'h7, 8'h34);
		#1 chk("auto word strobe", 32'h1, n_wr_strobe - snap);
		wr(4'h2, 8'h00);
		snap = n_wr_strobe;
		wr(4'h4, 8'h56);
		wr(4'h5, 8'h78);
		#1 chk("byte strobe", 32'h1, n_wr_strobe - snap);
		wr(4'h2, 8'h01);
		snap = n_wr_strobe;
		wr(4'h5, 8'hbc);
		wr(4'h6, 8'hde);
		#1 chk("half-word strobe", 32'h1, n_wr_strobe - snap);
		wr(4'h2, 8'h02);
		snap = n_wr_strobe;
		wr(4'h6, 8'h66);
		wr(4'h7, 8'h77);
		#1 chk("word strobe", 32'h1, n_wr_strobe - snap);
		snap = n_rd_strobe;
		rd(4'h4, 8'h56, "strobe read byte zero");
		rd(4'h5, 8'hbc, "strobe read byte one");
		chk("read strobe", 32'h1, n_rd_strobe - snap);
		$display("Test window strobes ended.");
		close_out();
	end
endmodule : testbench
